// file: hw/psp_defines.svh
// constants for the parallel slave port: sync depth, direction code, reset values
// assumes it is included by bare name from each design file that needs it
// ============================================================
// Functional notes
// [RULE_01] enable bit turns the 8-bit data port into a host-accessible slave port
// [RULE_02] enable assigns three control pins as read, write and chip-select strobes
// [RULE_03] strobes work only with all three control pin directions set to input
// [RULE_04] host is asynchronous; strobes are synchronised before the device acts
// [RULE_05] host sees one eight-bit latch, read or written over the data lines
// [RULE_06] write starts when select and write first seen low, ends when either high
// [RULE_07] write end sets the interrupt flag and the input-full flag
// [RULE_08] read start drives the output latch onto the pins and sets output-full
// [RULE_09] software write during a read shows at once and leaves output-full clear
// [RULE_10] read end releases the data pins and sets the interrupt flag
// [RULE_11] slave port works only in single-chip mode, not external-bus mode
// [RULE_12] interrupt flag holds until cleared; input-full clears when data is read
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH

// ============================================================
// sizes and codes
`define PSP_DATA_W 8
`define PSP_SYNC_STAGES 2
`define PSP_DIR_ALL_IN 3'h7

// ============================================================
// reset values
`define PSP_DATA_RST 8'h00
`define PSP_FLAG_RST 1'b0

`endif

// file: hw/psp_pkg.sv
// types shared by the parallel slave port modules
// assumes psp_defines.svh sits on the include path
`default_nettype none
`include "psp_defines.svh"

package psp_pkg;
    typedef logic [`PSP_DATA_W-1:0] psp_byte_t;
    typedef enum logic [1:0] {PSP_IDLE, PSP_WRITING, PSP_READING} psp_state_t;
endpackage

`default_nettype wire

// file: hw/psp_if.sv
// synchronised host strobes and data carried from the synchroniser to the core
// assumes both ends run on sys_clk
`timescale 1ns/1ps
`default_nettype none

interface psp_if;
    logic csLow;
    logic wrLow;
    logic rdLow;
    psp_pkg::psp_byte_t data;
    modport syncSide (output csLow, output wrLow, output rdLow, output data);
    modport coreSide (input csLow, input wrLow, input rdLow, input data);
endinterface

`default_nettype wire

// file: hw/psp_sync.sv
// multi-stage synchroniser for the host strobes and data lines
// assumes raw pins are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "psp_defines.svh"

module psp_sync #(
    parameter int STAGES = `PSP_SYNC_STAGES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic csN,
    input wire logic wrN,
    input wire logic rdN,
    input wire psp_pkg::psp_byte_t dataIn,
    psp_if.syncSide syncBus
);
    localparam int W = `PSP_DATA_W + 3;

    // ============================================================
    // elaboration check
    if (STAGES < 2) begin : g_bad_stages
        $error("psp_sync needs at least two stages");
    end

    // ============================================================
    // stage chain; only the next stage reads each flop before the last
    logic [W-1:0] stage_reg [STAGES];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_reg[0] <= {3'h7, `PSP_DATA_RST};
        end else begin
            stage_reg[0] <= {csN, wrN, rdN, dataIn}; // RULE_04
        end
    end

    for (genvar i = 1; i < STAGES; i++) begin : g_stage
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                stage_reg[i] <= {3'h7, `PSP_DATA_RST};
            end else begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    assign syncBus.csLow = ~stage_reg[STAGES-1][W-1];
    assign syncBus.wrLow = ~stage_reg[STAGES-1][W-2];
    assign syncBus.rdLow = ~stage_reg[STAGES-1][W-3];
    assign syncBus.data = stage_reg[STAGES-1][`PSP_DATA_W-1:0];
endmodule

`default_nettype wire

// file: hw/psp_top.sv
// parallel slave port core: host strobe handling, latches and status flags
// assumes software-side strobes are one-cycle pulses on sys_clk; host pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "psp_defines.svh"

module psp_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic slave_port_enable,
    input wire logic singleChipMode,
    input wire logic [2:0] control_pin_direction,
    input wire logic csN,
    input wire logic wrN,
    input wire logic rdN,
    input wire psp_pkg::psp_byte_t dataIn,
    output logic [`PSP_DATA_W-1:0] dataOut,
    output logic dataOe,
    input wire logic swWriteStb,
    input wire psp_pkg::psp_byte_t swWriteData,
    input wire logic swReadStb,
    input wire logic swClearIrq,
    input wire logic swClearOutFull,
    output logic [`PSP_DATA_W-1:0] inputData,
    output logic input_buffer_full,
    output logic output_buffer_full,
    output logic slave_port_irq_flag
);
    // ============================================================
    // synchronised host side
    psp_if syncBus ();

    psp_sync #(.STAGES(`PSP_SYNC_STAGES)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .csN(csN),
        .wrN(wrN),
        .rdN(rdN),
        .dataIn(dataIn),
        .syncBus(syncBus)
    );

    function automatic logic accessReq(input logic selLow, input logic strobeLow);
        accessReq = selLow & strobeLow;
    endfunction

    // ============================================================
    // port gating and access state
    logic portOn;
    logic writeReq;
    logic readReq;
    logic writeEnd;
    logic readStart;
    logic readEnd;
    psp_pkg::psp_state_t state_reg;
    psp_pkg::psp_state_t state_next;
    psp_pkg::psp_byte_t captured_reg;
    psp_pkg::psp_byte_t inLatch_reg;
    psp_pkg::psp_byte_t outLatch_reg;
    logic inFull_reg;
    logic outFull_reg;
    logic irq_reg;

    // direction check is a guard only; the strobes are inputs whatever it says
    assign portOn = slave_port_enable // RULE_01
        & singleChipMode // RULE_11
        & (control_pin_direction == `PSP_DIR_ALL_IN); // RULE_03
    assign writeReq = accessReq(syncBus.csLow, syncBus.wrLow); // RULE_02
    assign readReq = accessReq(syncBus.csLow, syncBus.rdLow); // RULE_02

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            psp_pkg::PSP_IDLE: begin
                if (writeReq) begin
                    state_next = psp_pkg::PSP_WRITING; // RULE_06
                end else if (readReq) begin
                    state_next = psp_pkg::PSP_READING; // RULE_08
                end
            end
            psp_pkg::PSP_WRITING: begin
                if (!writeReq) begin
                    state_next = psp_pkg::PSP_IDLE; // RULE_06
                end
            end
            psp_pkg::PSP_READING: begin
                if (!readReq) begin
                    state_next = psp_pkg::PSP_IDLE; // RULE_10
                end
            end
            default: state_next = psp_pkg::PSP_IDLE;
        endcase
        if (!portOn) begin
            state_next = psp_pkg::PSP_IDLE;
        end
    end

    assign writeEnd = portOn && state_reg == psp_pkg::PSP_WRITING && !writeReq;
    assign readEnd = portOn && state_reg == psp_pkg::PSP_READING && !readReq;
    assign readStart = state_reg != psp_pkg::PSP_READING && state_next == psp_pkg::PSP_READING;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= psp_pkg::PSP_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ============================================================
    // input latch: last byte seen while both strobes were low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            captured_reg <= `PSP_DATA_RST;
        end else if (state_reg == psp_pkg::PSP_WRITING && writeReq) begin
            captured_reg <= syncBus.data; // RULE_05
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            inLatch_reg <= `PSP_DATA_RST;
        end else if (writeEnd) begin
            inLatch_reg <= captured_reg; // RULE_07
        end
    end

    // ============================================================
    // output latch and pin drive
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            outLatch_reg <= `PSP_DATA_RST;
        end else if (swWriteStb) begin
            outLatch_reg <= swWriteData; // RULE_09
        end
    end

    assign dataOut = outLatch_reg;
    assign dataOe = state_reg == psp_pkg::PSP_READING; // RULE_08 RULE_10
    assign inputData = inLatch_reg;

    // ============================================================
    // status flags; a setting event beats a clear in the same cycle, except a software write at read start clears output-full
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            inFull_reg <= `PSP_FLAG_RST;
        end else if (writeEnd) begin
            inFull_reg <= 1'b1; // RULE_07
        end else if (swReadStb) begin
            inFull_reg <= 1'b0; // RULE_12
        end
    end

    // a software write during a read wins over the read's set
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            outFull_reg <= `PSP_FLAG_RST;
        end else if (swWriteStb && (dataOe || readStart)) begin
            outFull_reg <= 1'b0; // RULE_09
        end else if (readStart) begin
            outFull_reg <= 1'b1; // RULE_08
        end else if (swClearOutFull) begin
            outFull_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= `PSP_FLAG_RST;
        end else if (writeEnd || readEnd) begin
            irq_reg <= 1'b1; // RULE_07 RULE_10
        end else if (swClearIrq) begin
            irq_reg <= 1'b0; // RULE_12
        end
    end

    assign input_buffer_full = inFull_reg;
    assign output_buffer_full = outFull_reg;
    assign slave_port_irq_flag = irq_reg;

    // ============================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_off_no_drive;
        !slave_port_enable |=> !dataOe;
    endproperty
    a_off_no_drive: assert property (p_off_no_drive) else $error("pins driven while port disabled"); // RULE_01

    property p_drive_needs_strobes;
        dataOe |-> $past(syncBus.csLow) && $past(syncBus.rdLow);
    endproperty
    a_drive_needs_strobes: assert property (p_drive_needs_strobes) else $error("drive without read strobes"); // RULE_02

    property p_dir_guard;
        control_pin_direction != `PSP_DIR_ALL_IN |=> !dataOe;
    endproperty
    a_dir_guard: assert property (p_dir_guard) else $error("drive with wrong pin direction"); // RULE_03

    property p_sync_latency;
        $past(state_reg) == psp_pkg::PSP_IDLE && state_reg == psp_pkg::PSP_WRITING
            |-> $past(!csN && !wrN, 3);
    endproperty
    a_sync_latency: assert property (p_sync_latency) else $error("write began without synced strobes"); // RULE_04

    property p_write_ends;
        writeEnd |=> state_reg != psp_pkg::PSP_WRITING;
    endproperty
    a_write_ends: assert property (p_write_ends) else $error("write cycle did not end"); // RULE_06

    property p_write_flags;
        writeEnd |=> input_buffer_full && slave_port_irq_flag && inputData == $past(captured_reg);
    endproperty
    a_write_flags: assert property (p_write_flags) else $error("write end flags or data wrong"); // RULE_07

    property p_read_start;
        readStart && !swWriteStb |=> dataOe && output_buffer_full && dataOut == $past(outLatch_reg);
    endproperty
    a_read_start: assert property (p_read_start) else $error("read start did not drive or flag"); // RULE_08

    property p_write_during_read;
        dataOe && swWriteStb |=> dataOut == $past(swWriteData) && !output_buffer_full;
    endproperty
    a_write_during_read: assert property (p_write_during_read) else $error("write during read mishandled"); // RULE_09

    property p_read_end;
        readEnd |=> !dataOe && slave_port_irq_flag;
    endproperty
    a_read_end: assert property (p_read_end) else $error("read end did not release or flag"); // RULE_10

    property p_mode_guard;
        !singleChipMode |=> state_reg == psp_pkg::PSP_IDLE [*2];
    endproperty
    a_mode_guard: assert property (p_mode_guard) else $error("port active outside single-chip mode"); // RULE_11

    property p_irq_holds;
        slave_port_irq_flag && !swClearIrq |=> slave_port_irq_flag;
    endproperty
    a_irq_holds: assert property (p_irq_holds) else $error("interrupt flag dropped on its own"); // RULE_12

    property p_in_full_clear;
        swReadStb && !writeEnd |=> !input_buffer_full;
    endproperty
    a_in_full_clear: assert property (p_in_full_clear) else $error("input-full flag not cleared by read"); // RULE_12

    c_write_done: cover property (writeEnd ##1 input_buffer_full);
    c_read_done: cover property (readStart ##[1:20] readEnd);
    c_write_in_read: cover property (dataOe && swWriteStb);
endmodule

`default_nettype wire

// file: sim/psp_host_model.sv
// host processor model: drives the slave port strobes and data lines
// assumes the device clock is visible; all changes land on its falling edge
`timescale 1ns/1ps
`default_nettype none

module psp_host_model (
    input wire logic sys_clk,
    input wire psp_pkg::psp_byte_t dataOut,
    input wire logic dataOe,
    output var logic csN,
    output var logic wrN,
    output var logic rdN,
    output var psp_pkg::psp_byte_t dataIn
);
    psp_pkg::psp_byte_t lastRead;

    // ============================================================
    // idle bus
    initial begin
        csN = 1'h1;
        wrN = 1'h1;
        rdN = 1'h1;
        dataIn = 8'hA5;
        lastRead = 8'h00;
    end

    // ============================================================
    // write cycle; data held past the strobe since capture runs until end is seen
    task automatic hostWrite(input psp_pkg::psp_byte_t value, input int lowCycles, input logic wrOnly);
        @(negedge sys_clk);
        dataIn = value;
        csN = 1'h0;
        wrN = 1'h0;
        repeat (lowCycles) @(negedge sys_clk);
        wrN = 1'h1;
        if (!wrOnly) begin
            csN = 1'h1;
        end
        repeat (2) @(negedge sys_clk);
        csN = 1'h1;
        dataIn = ~value; // released lines must not keep showing the byte
    endtask

    // ============================================================
    // read cycle, split so the bench can act while it is open
    task automatic readStart;
        @(negedge sys_clk);
        csN = 1'h0;
        rdN = 1'h0;
    endtask

    task automatic readEnd;
        @(negedge sys_clk);
        lastRead = dataOe ? dataOut : ~lastRead;
        csN = 1'h1;
        rdN = 1'h1;
    endtask
endmodule

`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the parallel slave port core
// assumes psp_top and the host model are compiled before it
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic sys_clk;
    logic rst_n;
    logic enable;
    logic singleChipMode;
    logic [2:0] dirBits;
    logic swWriteStb;
    psp_pkg::psp_byte_t swWriteData;
    logic swReadStb;
    logic swClearIrq;
    logic swClearOutFull;
    wire logic csN;
    wire logic wrN;
    wire logic rdN;
    wire psp_pkg::psp_byte_t dataIn;
    psp_pkg::psp_byte_t dataOut;
    psp_pkg::psp_byte_t inputData;
    logic dataOe;
    logic inFull;
    logic outFull;
    logic irq;
    int fails;
    int comparisons;

    psp_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .slave_port_enable(enable), .singleChipMode(singleChipMode),
        .control_pin_direction(dirBits), .csN(csN), .wrN(wrN), .rdN(rdN), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .swWriteStb(swWriteStb), .swWriteData(swWriteData), .swReadStb(swReadStb),
        .swClearIrq(swClearIrq), .swClearOutFull(swClearOutFull), .inputData(inputData),
        .input_buffer_full(inFull), .output_buffer_full(outFull), .slave_port_irq_flag(irq));

    psp_host_model hostModel (.sys_clk(sys_clk), .dataOut(dataOut), .dataOe(dataOe), .csN(csN), .wrN(wrN),
        .rdN(rdN), .dataIn(dataIn));

    // ============================================================
    // helpers
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic flagOf(input int which);
        case (which)
            0: return inFull;
            1: return outFull;
            2: return irq;
            default: return dataOe;
        endcase
    endfunction

    // bounded wait; a flag that never comes ends the run
    task automatic waitFor(input int which, input logic level);
        int n;
        n = 0;
        while (flagOf(which) !== level && n < 12) begin
            @(negedge sys_clk);
            n++;
        end
        if (flagOf(which) !== level) begin
            fails++;
            $display("MISMATCH flag %0d expected %b seen %b", which, level, flagOf(which));
            report_and_stop();
        end
    endtask

    task automatic pulse(input int which, input psp_pkg::psp_byte_t value);
        @(negedge sys_clk);
        swWriteData = value;
        case (which)
            0: swWriteStb = 1'h1;
            1: swReadStb = 1'h1;
            2: swClearIrq = 1'h1;
            default: swClearOutFull = 1'h1;
        endcase
        @(negedge sys_clk);
        swWriteStb = 1'h0;
        swReadStb = 1'h0;
        swClearIrq = 1'h0;
        swClearOutFull = 1'h0;
    endtask

    // ============================================================
    // scenarios
    task automatic testWrite;
        psp_pkg::psp_byte_t vals [2] = '{8'h5A, 8'hC3};
        for (int i = 0; i < 2; i++) begin
            hostModel.hostWrite(vals[i], 3 + i, i[0]);
            waitFor(0, 1'h1);
            chk("host byte", vals[i], inputData);
            chk("irq after write", 8'h01, {7'h00, irq});
            pulse(1, 8'h00);
            chk("in full after sw read", 8'h02, {6'h00, irq, inFull});
            pulse(2, 8'h00);
            chk("irq after clear", 8'h00, {7'h00, irq});
        end
        $display("test write done");
    endtask

    task automatic testRead;
        pulse(0, 8'h3C);
        chk("latch idle", 8'h3C, dataOut);
        chk("pins idle", 8'h00, {7'h00, dataOe});
        hostModel.readStart();
        waitFor(3, 1'h1);
        chk("read data", 8'h3C, dataOut);
        chk("out full irq in read", 8'h02, {6'h00, outFull, irq});
        pulse(0, 8'h96);
        chk("new data at once", 8'h96, dataOut);
        chk("out full after sw write", 8'h00, {7'h00, outFull});
        hostModel.readEnd();
        waitFor(3, 1'h0);
        chk("irq after read", 8'h01, {7'h00, irq});
        chk("host saw", 8'h96, hostModel.lastRead);
        pulse(2, 8'h00);
        // plain read: output-full stays set until software clears it
        hostModel.readStart();
        waitFor(3, 1'h1);
        chk("out full plain read", 8'h01, {7'h00, outFull});
        hostModel.readEnd();
        waitFor(3, 1'h0);
        chk("out full irq after read", 8'h03, {6'h00, outFull, irq});
        chk("host saw latch", 8'h96, hostModel.lastRead);
        pulse(3, 8'h00);
        chk("out full after clear", 8'h00, {7'h00, outFull});
        pulse(2, 8'h00);
        $display("test read done");
    endtask

    // each case breaks one condition; the port must act as if absent
    task automatic testDisabled;
        for (int k = 0; k < 3; k++) begin
            enable = (k != 0);
            singleChipMode = (k != 1);
            dirBits = (k == 2) ? 3'h6 : 3'h7;
            hostModel.hostWrite(8'hE7, 4, 1'h0);
            hostModel.readStart();
            repeat (8) @(negedge sys_clk);
            chk("pins when off", 8'h00, {7'h00, dataOe});
            hostModel.readEnd();
            repeat (4) @(negedge sys_clk);
            chk("flags when off", 8'h00, {5'h00, inFull, outFull, irq});
            chk("data when off", 8'hC3, inputData);
        end
        enable = 1'h1;
        singleChipMode = 1'h1;
        dirBits = 3'h7;
        $display("test disabled done");
    endtask

    // ============================================================
    // clock and main sequence
    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial begin
        fails = 0;
        comparisons = 0;
        rst_n = 1'h0;
        enable = 1'h1;
        singleChipMode = 1'h1;
        dirBits = 3'h7;
        swWriteStb = 1'h0;
        swWriteData = 8'h00;
        swReadStb = 1'h0;
        swClearIrq = 1'h0;
        swClearOutFull = 1'h0;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'h1;
        @(negedge sys_clk);
        chk("reset state", 8'h00, {4'h0, inFull, outFull, irq, dataOe});
        testWrite();
        testRead();
        testDisabled();
        report_and_stop();
    end
endmodule

`default_nettype wire
